/* File: hdl/ocpc_consts.vh */
// constants of the four-channel output compare / pwm block
`ifndef OCPC_CONSTS_VH
`define OCPC_CONSTS_VH
// register indices, byte address is four times the index
`define OCPC_IDX_CH1_SEC   10'h180
`define OCPC_IDX_CH1_MAIN  10'h182
`define OCPC_IDX_CH1_CTL   10'h184
`define OCPC_IDX_CH2_SEC   10'h186
`define OCPC_IDX_CH2_MAIN  10'h188
`define OCPC_IDX_CH2_CTL   10'h18a
`define OCPC_IDX_CH3_SEC   10'h18c
`define OCPC_IDX_CH3_MAIN  10'h18e
`define OCPC_IDX_CH3_CTL   10'h190
`define OCPC_IDX_CH4_SEC   10'h192
`define OCPC_IDX_CH4_MAIN  10'h194
`define OCPC_IDX_CH4_CTL   10'h196
`define OCPC_IDX_FLAGS     10'h198
`define OCPC_IDX_ENABLES   10'h199
// index step between registers, and count of channel registers
`define OCPC_CH_STRIDE     10'h002
`define OCPC_CH_SPAN       10'h00c
// control register fields
`define OCPC_MODE_LSB      0
`define OCPC_MODE_MSB      2
`define OCPC_TSEL_BIT      3
`define OCPC_FLT_BIT       4
`define OCPC_SIDL_BIT      13
`define OCPC_CTL_WMASK     16'h200f
// mode codes
`define OCPC_M_OFF         3'h0
`define OCPC_M_LOW         3'h1
`define OCPC_M_HIGH        3'h2
`define OCPC_M_TOGGLE      3'h3
`define OCPC_M_DSINGLE     3'h4
`define OCPC_M_DCONT       3'h5
`define OCPC_M_PWM         3'h6
`define OCPC_M_PWMF        3'h7
// reset values
`define OCPC_RST_REG       16'h0000
`define OCPC_RST_FLAGS     4'h0
`endif

/* File: hdl/ocpc_top.v */
// four output compare / pwm channels with apb register access
//
// Contract
// RQ1: mode field codes 1-3 select simple compare
// RQ2: simple modes change pin only on equality
// RQ3: codes 4 and 5 select dual compare
// RQ4: software loads start, stop, period first
// RQ5: rewrite mode 4 for another pulse
// RQ6: continuous pulses: load, mode 5, timer on
// RQ7: pwm modes, main latch read-only, buffered
// RQ8: software pwm setup order is prescribed
// RQ9: mode 7 fault low tri-states, sets flag
// RQ10: fault holds until removed and rewritten
// RQ11: pwm period is timer period plus one
// RQ12: period match sets pin, latches, flags
// RQ13: duty zero low, above period high
// RQ14: sleep holds pin level
// RQ15: idle runs only if enabled, no halts
// RQ16: non-pwm compare events set sticky flag
// RQ17: pwm events use timer flag only
// RQ18: select bit chooses timer, first default
// RQ19: dual: main sets, secondary clears pin
// RQ20: mode zero disables, pin low, no events
//
// Our own choice: the APB register port.
`include "ocpc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ocpc_top
(
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg         pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // first timebase
   input  wire [15:0] timebase_count_a,
   input  wire [15:0] timer_period_register_a,
   input  wire        timebase_tick_a,
   input  wire        timer_run_bit_a,
   input  wire        timer_halt_in_idle_bit_a,
   // second timebase
   input  wire [15:0] timebase_count_b,
   input  wire [15:0] timer_period_register_b,
   input  wire        timebase_tick_b,
   input  wire        timer_run_bit_b,
   input  wire        timer_halt_in_idle_bit_b,
   // cpu power state
   input  wire        cpu_sleep,
   input  wire        cpu_idle,
   // fault pin, active low, asynchronous
   input  wire        fault_input_pin_n,
   // compare outputs
   output reg  [3:0]  compare_output_pin,
   output reg  [3:0]  compare_output_pin_oe,
   // events
   output reg  [3:0]  compare_event_irq,
   output reg         first_timer_event_flag,
   output reg         second_timer_event_flag
);

   reg [15:0] sec_q  [0:3];
   reg [15:0] sec_d  [0:3];
   reg [15:0] main_q [0:3];
   reg [15:0] main_d [0:3];
   reg [15:0] ctl_q  [0:3];
   reg [15:0] ctl_d  [0:3];
   reg [3:0]  pin_q;
   reg [3:0]  pin_d;
   reg [3:0]  done_q;
   reg [3:0]  done_d;
   reg [3:0]  flt_q;
   reg [3:0]  flt_d;
   reg [3:0]  flag_q;
   reg [3:0]  flag_d;
   reg [3:0]  en_q;
   reg [3:0]  en_d;
   reg        ta_evt;
   reg        tb_evt;
   reg        flt_meta_q;
   reg        flt_sync_q;
   reg [31:0] rd_d;
   reg        err_d;
   reg [2:0]  mode;
   reg [15:0] cnt;
   reg [15:0] per;
   reg [15:0] nxt;
   reg [15:0] duty;
   reg        tick;
   reg        run;
   reg        ev;
   reg        hit_main;
   reg        hit_sec;
   reg        sel;
   integer    i;
   integer    j;

   wire       setup  = psel & ~penable;
   wire       access = psel & penable & pready;
   wire       wr     = access & pwrite;
   wire [9:0] idx    = paddr[11:2];

   // decode {valid, channel, kind}: kind 0 secondary, 1 main, 2 control
   // channel registers sit on even indices, two apart
   function [4:0] dec;
      input [9:0] a;
      reg   [9:0] o;
      reg   [9:0] q;
      reg   [9:0] r;
      begin
         o = a - `OCPC_IDX_CH1_SEC;
         q = {1'b0, o[9:1]} / 10'd3;
         r = {1'b0, o[9:1]} % 10'd3;
         if (a >= `OCPC_IDX_CH1_SEC && !o[0] && {1'b0, o[9:1]} < `OCPC_CH_SPAN)
            dec = {1'b1, q[1:0], r[1:0]};
         else
            dec = 5'h00;
      end
   endfunction

   wire [4:0] dc = dec(idx);

   // fault pin synchroniser
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flt_meta_q <= 1'b1;
         flt_sync_q <= 1'b1;
      end
      else
      begin
         flt_meta_q <= fault_input_pin_n;
         flt_sync_q <= flt_meta_q;
      end
   end

   // channel behaviour and register writes
   always @*
   begin
      pin_d  = pin_q;
      done_d = done_q;
      flt_d  = flt_q;
      flag_d = flag_q;
      en_d   = en_q;
      ta_evt = 1'b0;
      tb_evt = 1'b0;
      mode = 3'h0;
      cnt = 16'h0;
      per = 16'h0;
      nxt = 16'h0;
      duty = 16'h0;
      tick = 1'b0;
      run = 1'b0;
      ev = 1'b0;
      hit_main = 1'b0;
      hit_sec = 1'b0;
      sel = 1'b0;
      for (i = 0; i < 4; i = i + 1)
      begin
         sec_d[i]  = sec_q[i];
         main_d[i] = main_q[i];
         ctl_d[i]  = ctl_q[i];
         mode = ctl_q[i][`OCPC_MODE_MSB:`OCPC_MODE_LSB];
         sel  = ctl_q[i][`OCPC_TSEL_BIT];
         // timer select, first timebase when clear
         cnt  = sel ? timebase_count_b : timebase_count_a;             // RQ18
         per  = sel ? timer_period_register_b : timer_period_register_a;
         tick = sel ? timebase_tick_b : timebase_tick_a;
         // sleep freezes; idle needs timer on and no halt bits
         run  = !cpu_sleep &&                                          // RQ14
                !(cpu_idle && (ctl_q[i][`OCPC_SIDL_BIT] ||             // RQ15
                  !(sel ? timer_run_bit_b : timer_run_bit_a) ||
                  (sel ? timer_halt_in_idle_bit_b : timer_halt_in_idle_bit_a)));
         // timer wraps after its period, so a period spans period plus one ticks
         nxt  = (cnt == per) ? 16'h0000 : cnt + 16'h0001;              // RQ11
         hit_main = (cnt == main_q[i]);                                // RQ2
         hit_sec  = (cnt == sec_q[i]);
         ev = 1'b0;
         if (mode == `OCPC_M_OFF)
         begin
            pin_d[i]  = 1'b0;                                          // RQ20
            done_d[i] = 1'b0;
         end
         else if (run && tick)
         begin
            case (mode)
               `OCPC_M_LOW:                                            // RQ1
               begin
                  if (hit_main)
                  begin
                     pin_d[i] = 1'b0;
                     ev = 1'b1;
                  end
               end
               `OCPC_M_HIGH:
               begin
                  if (hit_main)
                  begin
                     pin_d[i] = 1'b1;
                     ev = 1'b1;
                  end
               end
               `OCPC_M_TOGGLE:
               begin
                  if (hit_main)
                  begin
                     pin_d[i] = ~pin_q[i];
                     ev = 1'b1;
                  end
               end
               `OCPC_M_DSINGLE,
               `OCPC_M_DCONT:                                          // RQ3
               begin
                  if (!done_q[i] && hit_main)
                  begin
                     pin_d[i] = 1'b1;                                  // RQ19
                     ev = 1'b1;
                  end
                  if (!done_q[i] && hit_sec)
                  begin
                     pin_d[i] = 1'b0;                                  // RQ19
                     ev = 1'b1;
                     if (mode == `OCPC_M_DSINGLE)
                        done_d[i] = 1'b1;                              // RQ19
                  end
               end
               `OCPC_M_PWM,
               `OCPC_M_PWMF:                                           // RQ7
               begin
                  duty = main_q[i];
                  if (cnt == per)
                  begin
                     main_d[i] = sec_q[i];                             // RQ12
                     duty = sec_q[i];
                     if (sel)
                        tb_evt = 1'b1;                                 // RQ17
                     else
                        ta_evt = 1'b1;                                 // RQ17
                  end
                  // high while count below duty: zero stays low, above period stays high
                  pin_d[i] = (nxt < duty);                             // RQ13
               end
               default:
               begin
                  pin_d[i] = pin_q[i];
               end
            endcase
         end
         // sticky compare flag, set wins over clear
         flag_d[i] = (flag_q[i] & ~(wr && idx == `OCPC_IDX_FLAGS && pwdata[i]))
                     | ev;                                             // RQ16
         // register writes
         if (wr && dc[4] && dc[3:2] == i[1:0])
         begin
            case (dc[1:0])
               2'd0:
               begin
                  sec_d[i] = pwdata[15:0];                             // RQ7
               end
               2'd1:
               begin
                  // active duty latch is read-only in pwm
                  if (mode[2:1] != 2'b11)
                     main_d[i] = pwdata[15:0];                         // RQ7
               end
               default:
               begin
                  ctl_d[i] = pwdata[15:0] & `OCPC_CTL_WMASK;           // RQ1
                  // any mode write re-arms, so a spent single pulse never blocks a new mode
                  done_d[i] = 1'b0;                                    // RQ5
                  // fault clears on rewrite only once the pin has recovered
                  if (flt_sync_q)
                     flt_d[i] = 1'b0;                                  // RQ10
               end
            endcase
         end
         // fault latch, set wins over rewrite
         if (ctl_q[i][`OCPC_MODE_MSB:`OCPC_MODE_LSB] == `OCPC_M_PWMF && !flt_sync_q)
            flt_d[i] = 1'b1;                                           // RQ9
      end
      if (wr && idx == `OCPC_IDX_ENABLES)
         en_d = pwdata[3:0];
   end

   // read mux, sampled in the setup cycle, answered in the access cycle
   always @*
   begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      if (dc[4])
      begin
         case (dc[1:0])
            2'd0:
               rd_d[15:0] = sec_q[dc[3:2]];
            2'd1:
               rd_d[15:0] = main_q[dc[3:2]];
            default:
            begin
               rd_d[15:0] = ctl_q[dc[3:2]];
               rd_d[`OCPC_FLT_BIT] = flt_q[dc[3:2]];                   // RQ9
            end
         endcase
      end
      else if (idx == `OCPC_IDX_FLAGS)
         rd_d[3:0] = flag_q;
      else if (idx == `OCPC_IDX_ENABLES)
         rd_d[3:0] = en_q;
      else
         err_d = 1'b1;
   end

   // state registers
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (j = 0; j < 4; j = j + 1)
         begin
            sec_q[j]  <= `OCPC_RST_REG;
            main_q[j] <= `OCPC_RST_REG;
            ctl_q[j]  <= `OCPC_RST_REG;
         end
         pin_q  <= 4'h0;
         done_q <= 4'h0;
         flt_q  <= 4'h0;
         flag_q <= `OCPC_RST_FLAGS;
         en_q   <= `OCPC_RST_FLAGS;
      end
      else
      begin
         for (j = 0; j < 4; j = j + 1)
         begin
            sec_q[j]  <= sec_d[j];
            main_q[j] <= main_d[j];
            ctl_q[j]  <= ctl_d[j];
         end
         pin_q  <= pin_d;
         done_q <= done_d;
         flt_q  <= flt_d;
         flag_q <= flag_d;
         en_q   <= en_d;
      end
   end

   // apb answer: one access cycle, zero wait
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h0000_0000 : rd_d;
         pslverr <= err_d;
      end
      else
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // pin and event outputs
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         compare_output_pin      <= 4'h0;
         compare_output_pin_oe   <= 4'hf;
         compare_event_irq       <= 4'h0;
         first_timer_event_flag  <= 1'b0;
         second_timer_event_flag <= 1'b0;
      end
      else
      begin
         compare_output_pin      <= pin_d & ~flt_d;
         // faulted channel releases its pin
         compare_output_pin_oe   <= ~flt_d;                            // RQ9
         compare_event_irq       <= flag_d & en_d;                     // RQ16
         first_timer_event_flag  <= ta_evt;                            // RQ12
         second_timer_event_flag <= tb_evt;                            // RQ12
      end
   end

endmodule // ocpc_top
`default_nettype wire

/* File: dv/ocpc_props.sv */
// port assertions of the output compare block
`timescale 1ns/1ps
`default_nettype none
module ocpc_props
(
   // clock and reset
   input wire        clk,
   input wire        rst_n,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire        pready,
   input wire [31:0] prdata,
   input wire        pslverr,
   // timebases, sleep, fault
   input wire [15:0] timebase_count_a,
   input wire [15:0] timer_period_register_a,
   input wire        timebase_tick_a,
   input wire        timebase_tick_b,
   input wire        cpu_sleep,
   input wire        fault_input_pin_n,
   // outputs
   input wire [3:0]  compare_output_pin,
   input wire [3:0]  compare_output_pin_oe,
   input wire [3:0]  compare_event_irq,
   input wire        first_timer_event_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire wr = psel && penable && pwrite && pready;
   wire tk = timebase_tick_a || timebase_tick_b;
   a_ready_after_setup: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_pin_on_cause: assert property ($changed(compare_output_pin) |-> $past(tk || wr) ||
      $changed(compare_output_pin_oe) || !$past(fault_input_pin_n, 3)) else $error("pin moved without cause");
   a_sleep_hold: assert property (cpu_sleep && $past(cpu_sleep) |-> $stable(compare_output_pin))
      else $error("pin moved in sleep");
   a_fault_pin_low: assert property ((compare_output_pin & ~compare_output_pin_oe) == 4'h0)
      else $error("released pin not low");
   a_oe_fall_fault: assert property (|($past(compare_output_pin_oe) & ~compare_output_pin_oe) |->
      !$past(fault_input_pin_n) || !$past(fault_input_pin_n, 2) || !$past(fault_input_pin_n, 3))
      else $error("release without fault");
   a_oe_rise_write: assert property (|(~$past(compare_output_pin_oe) & compare_output_pin_oe) |->
      $past(wr && fault_input_pin_n)) else $error("drive resumed without write");
   a_timer_flag_wrap: assert property (first_timer_event_flag |->
      $past(timebase_tick_a && timebase_count_a == timer_period_register_a)) else $error("timer flag off wrap");
   a_timer_flag_pulse: assert property (first_timer_event_flag |=> !first_timer_event_flag)
      else $error("timer flag too long");
   a_irq_on_cause: assert property (|(~$past(compare_event_irq) & compare_event_irq) |-> $past(tk || wr))
      else $error("irq without event");
   c_fault: cover property (compare_output_pin_oe != 4'hf);
   c_timer_flag: cover property (first_timer_event_flag);
   c_slverr: cover property (pslverr);
endmodule // ocpc_props
bind ocpc_top ocpc_props i_ocpc_props (.clk, .rst_n, .psel, .penable, .pwrite, .pready, .prdata, .pslverr,
   .timebase_count_a, .timer_period_register_a, .timebase_tick_a, .timebase_tick_b, .cpu_sleep,
   .fault_input_pin_n, .compare_output_pin, .compare_output_pin_oe, .compare_event_irq, .first_timer_event_flag);
`default_nettype wire

/* File: dv/ocpc_load.sv */
// load on the compare pins and fault source
`timescale 1ns/1ps
`default_nettype none
module ocpc_load
(
   // clock
   input wire        clk,
   // compare pins, fault request
   input wire [3:0]  pin,
   input wire [3:0]  oe,
   input wire        fault_req,
   // wire level, fault pin
   output logic [3:0] line,
   output logic       fault_input_pin_n
);
   logic [3:0] last_q = 4'h0;
   initial fault_input_pin_n = 1'h1;
   // a released pin floats: it shows a pattern that changes every cycle
   assign line = (pin & oe) | (~last_q & ~oe);
   always @(posedge clk)
   begin
      last_q <= line;
      fault_input_pin_n <= !fault_req;
   end
endmodule // ocpc_load
`default_nettype wire

/* File: dv/ocpc_tb_top.sv */
// register level bench of the output compare block
`include "ocpc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ocpc_tb_top;
   logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd;
   logic [15:0] cnt_a = 16'h0, cnt_b = 16'h0, per_a = 16'h14, per_b = 16'h1e;
   logic run_a = 1'h0, run_b = 1'h0, hid_a = 1'h0, hid_b = 1'h0, sleep = 1'h0, idle = 1'h0, fault_req = 1'h0;
   logic err;
   logic [7:0] po;
   wire pready, pslverr, tf_a, tf_b, fault_n;
   wire [31:0] prdata;
   wire [3:0] pin, oe, irq, line;
   int errors = 0, total_checks = 0, i, hi, chg, tf, tfb;
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      if (run_a) cnt_a <= (cnt_a == per_a) ? 16'h0 : cnt_a + 16'h1;
      if (run_b) cnt_b <= (cnt_b == per_b) ? 16'h0 : cnt_b + 16'h1;
   end
   ocpc_top i_ocpc_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .timebase_count_a(cnt_a), .timer_period_register_a(per_a), .timebase_tick_a(run_a), .timer_run_bit_a(run_a),
      .timer_halt_in_idle_bit_a(hid_a), .timebase_count_b(cnt_b), .timer_period_register_b(per_b),
      .timebase_tick_b(run_b), .timer_run_bit_b(run_b), .timer_halt_in_idle_bit_b(hid_b), .cpu_sleep(sleep),
      .cpu_idle(idle), .fault_input_pin_n(fault_n), .compare_output_pin(pin), .compare_output_pin_oe(oe),
      .compare_event_irq(irq), .first_timer_event_flag(tf_a), .second_timer_event_flag(tf_b));
   ocpc_load i_ocpc_load (.clk, .pin, .oe, .fault_req, .line, .fault_input_pin_n(fault_n));
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic stuck;
      errors++;
      complete_run();
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d);
      int k;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {16'h0, d};
      @(posedge clk);
      penable <= 1'h1;
      // answer is taken at the edge that samples pready high
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk);
         if (pready === 1'h1) break;
      end
      if (k == 20) stuck();
      rd = prdata;
      err = pslverr;
      po = {irq, oe};
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wait_pin(input int c, input logic v);
      int k;
      for (k = 0; k < 100; k++)
      begin
         #1;
         if (line[c] === v) break;
         @(posedge clk);
      end
      if (k == 100) stuck();
      @(posedge clk);
   endtask
   // two timer a periods of one pin: high cycles, changes, timer flags
   task automatic meas(input int c);
      logic v;
      repeat (24) @(posedge clk);
      #1;
      v = line[c];
      hi = 0;
      chg = 0;
      tf = 0;
      tfb = 0;
      repeat (42)
      begin
         @(posedge clk);
         #1;
         hi += (line[c] === 1'h1);
         chg += (line[c] !== v);
         tf += (tf_a === 1'h1);
         tfb += (tf_b === 1'h1);
         v = line[c];
      end
      @(posedge clk);
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      run_a <= 1'h1;
      run_b <= 1'h1;
      @(posedge clk);
      for (i = 0; i < 12; i++)
      begin
         apb(1'h0, `OCPC_IDX_CH1_SEC + 10'(2 * i), 16'h0);
         check(rd, 32'h0);
      end
      apb(1'h0, 10'h181, 16'h0);
      check({err, rd[30:0]}, 32'h80000000);
      apb(1'h1, `OCPC_IDX_CH1_CTL, 16'hffff);
      apb(1'h0, `OCPC_IDX_CH1_CTL, 16'h0);
      check(rd, 32'h200f);
      apb(1'h1, `OCPC_IDX_CH1_CTL, 16'h0);
      apb(1'h1, `OCPC_IDX_ENABLES, 16'hf);
      apb(1'h1, `OCPC_IDX_CH1_MAIN, 16'h5);
      apb(1'h1, `OCPC_IDX_CH1_CTL, 16'h2);
      wait_pin(0, 1'h1);
      apb(1'h1, `OCPC_IDX_CH1_CTL, 16'h1);
      wait_pin(0, 1'h0);
      apb(1'h1, `OCPC_IDX_CH1_CTL, 16'h3);
      wait_pin(0, 1'h1);
      apb(1'h0, `OCPC_IDX_FLAGS, 16'h0);
      check({rd[0], po[4]}, 32'h3);
      apb(1'h1, `OCPC_IDX_CH1_CTL, 16'h0);
      apb(1'h1, `OCPC_IDX_FLAGS, 16'hf);
      meas(0);
      check(hi + chg, 32'h0);
      apb(1'h0, `OCPC_IDX_FLAGS, 16'h0);
      check(rd, 32'h0);
      apb(1'h1, `OCPC_IDX_CH2_MAIN, 16'h19);
      apb(1'h1, `OCPC_IDX_CH2_CTL, 16'h2);
      meas(1);
      check(hi, 32'h0);
      apb(1'h1, `OCPC_IDX_CH2_CTL, 16'ha);
      wait_pin(1, 1'h1);
      run_a <= 1'h0;
      apb(1'h1, `OCPC_IDX_CH3_SEC, 16'h8);
      apb(1'h1, `OCPC_IDX_CH3_MAIN, 16'h4);
      apb(1'h1, `OCPC_IDX_CH3_CTL, 16'h4);
      run_a <= 1'h1;
      wait_pin(2, 1'h1);
      wait_pin(2, 1'h0);
      meas(2);
      check(hi, 32'h0);
      apb(1'h1, `OCPC_IDX_CH3_CTL, 16'h4);
      wait_pin(2, 1'h1);
      run_a <= 1'h0;
      apb(1'h1, `OCPC_IDX_CH3_CTL, 16'h5);
      run_a <= 1'h1;
      meas(2);
      check({hi, chg}, {32'h8, 32'h4});
      apb(1'h1, `OCPC_IDX_CH3_CTL, 16'h0);
      apb(1'h1, `OCPC_IDX_FLAGS, 16'hf);
      run_a <= 1'h0;
      apb(1'h1, `OCPC_IDX_CH4_SEC, 16'h7);
      apb(1'h1, `OCPC_IDX_CH4_CTL, 16'h6);
      run_a <= 1'h1;
      meas(3);
      check({hi, chg, tf}, {32'he, 32'h4, 32'h2});
      check(tfb, 32'h0);
      apb(1'h1, `OCPC_IDX_CH4_MAIN, 16'h3);
      apb(1'h0, `OCPC_IDX_CH4_MAIN, 16'h0);
      check(rd, 32'h7);
      apb(1'h0, `OCPC_IDX_FLAGS, 16'h0);
      check(rd[3], 32'h0);
      apb(1'h1, `OCPC_IDX_CH4_SEC, 16'h0);
      meas(3);
      check(hi, 32'h0);
      apb(1'h1, `OCPC_IDX_CH4_SEC, 16'h16);
      meas(3);
      check(hi, 32'h2a);
      apb(1'h1, `OCPC_IDX_CH4_SEC, 16'h7);
      for (i = 0; i < 4; i++)
      begin
         apb(1'h1, `OCPC_IDX_CH4_CTL, (i == 1) ? 16'h2006 : 16'h6);
         sleep <= (i == 0);
         idle <= (i > 0);
         hid_a <= (i == 2);
         meas(3);
         check(chg, (i == 3) ? 32'h4 : 32'h0);
         sleep <= 1'h0;
         idle <= 1'h0;
         hid_a <= 1'h0;
      end
      apb(1'h1, `OCPC_IDX_CH4_CTL, 16'h7);
      fault_req <= 1'h1;
      repeat (5) @(posedge clk);
      apb(1'h1, `OCPC_IDX_CH4_CTL, 16'h7);
      apb(1'h0, `OCPC_IDX_CH4_CTL, 16'h0);
      check({rd, po[3:0]}, {32'h17, 4'h7});
      fault_req <= 1'h0;
      repeat (5) @(posedge clk);
      apb(1'h0, `OCPC_IDX_CH4_CTL, 16'h0);
      check({rd, po[3:0]}, {32'h17, 4'h7});
      apb(1'h1, `OCPC_IDX_CH4_CTL, 16'h7);
      apb(1'h0, `OCPC_IDX_CH4_CTL, 16'h0);
      check({rd, po[3:0]}, {32'h7, 4'hf});
      complete_run();
   end
endmodule // ocpc_tb_top
`default_nettype wire
